// file: shared/pmc_pkg.sv
// Package with register map, field positions and shared types
package pmc_pkg;
   // Command codes
   localparam logic [7:0] CMD_STACK_TOPOLOGY    = 8'hEC;
   localparam logic [7:0] CMD_ASSORTED_SETTINGS = 8'hED;
   localparam logic [7:0] CMD_STRAP_PRIORITY    = 8'hEE;
   // Stack topology fields
   localparam int         FOLLOWER_LSB          = 0;
   localparam int         FOLLOWER_W            = 4;
   localparam logic [3:0] FOLLOWER_MAX          = 4'h3;
   localparam logic [3:0] STANDALONE_CODE       = 4'h0;
   // Assorted settings fields
   localparam int         PEC_REQ_BIT           = 15;
   localparam int         RELOAD_SHDN_BIT       = 14;
   localparam int         RELOAD_FLT_BIT        = 13;
   localparam int         RESET_MODE_BIT        = 12;
   localparam int         PULLUP_DIS_BIT        = 3;
   localparam int         FLT_CLR_BIT           = 2;
   localparam int         ADC_RESOLUTION_SEL_LSB           = 0;
   localparam logic [15:0] ASSORTED_WR_MASK     = 16'hF00F;
   // Strap priority fields
   localparam int         STRAP_TOPOLOGY_BIT    = 12;
   // Stored (nonvolatile) power-on values
   localparam logic [15:0] NVM_STACK_RST        = 16'h0000;
   localparam logic [15:0] NVM_ASSORTED_RST     = 16'h0000;
   localparam logic [15:0] NVM_STRAP_RST        = 16'h0000;
   // Word transaction request
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic        pec_ok;
      logic [7:0]  cmd;
      logic [15:0] data;
   } pmc_req_s;
   // Decoded configuration
   typedef struct packed {
      logic       pec_required;
      logic       reload_shutdown;
      logic       reload_fault;
      logic       reset_mode;
      logic       pullup_en;
      logic       fault_clear_mode;
      logic [1:0] adc_resolution_sel;
   } pmc_cfg_s;
endpackage : pmc_pkg

// file: logic/pmc_sync.sv
// Two-flop synchroniser for levels crossing into a clock domain
module pmc_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_in,
   input  wire logic         rstn_in,
   input  wire logic         ce_in,
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } pmc_sync_s;
   pmc_sync_s st_q;
   pmc_sync_s st_d;
   always_comb begin
      st_d    = st_q;
      st_d.s1 = d_in;
      st_d.s2 = st_q.s1;
   end
   always_ff @(posedge clk_in) begin
      // Keeps sampling through reset so the pin value is valid at release
      if (ce_in || !rstn_in) begin
         st_q <= st_d;
      end
   end
   assign q_out = st_q.s2;
endmodule : pmc_sync

// file: logic/pmc_config_regs.sv
// Configuration register bank for stack topology, assorted settings, strap priority
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Topology writes accepted only while conversion disabled; read-only otherwise
// - Topology upper byte reads zero; writes cannot change it
// - Stack base slot field always reads zero
// - Follower count 0 standalone, 1..3 followers; other codes invalid
// - Unsupported topology write rejected, invalid-data status raised, host notified
// - Standalone topology at power-up keeps backchannel pins disabled
// - Change to multi-phase does not enable backchannel before next power-up
// - Powered up multi-phase: topology changes live among valid values
// - PEC required bit set rejects transactions lacking PEC as invalid
// - Reload-on-shutdown bit resets voltage target to boot on shutdown
// - Reload-on-fault-retry bit resets target to boot on retry restart
// - Reset mode clear: pin is power good, pull-up off; set: reset
// - In reset mode pull-up enabled when pull-up disable bit is zero
// - Fault-free PWM cycle: decrement fault counter, or clear in clear mode
// - Two-bit ADC resolution field selects 12, 10, 8 or 6 bits
// - Strap priority bit set keeps pin-strapped value over stored value
// - Straps sampled only at power-on; written priority value is only read back, never used
// - Topology loaded from stored value or strap per strap bit 12
module pmc_config_regs (
   // System clock, reset and enable
   input  wire logic                 CLK_SYS_IN,
   input  wire logic                 RESETN_IN,
   input  wire logic                 CE_IN,
   // Backchannel link clock
   input  wire logic                 CLK_LINK_IN,
   // Word transaction port
   input  wire pmc_pkg::pmc_req_s    REQ_IN,
   output logic                      ACK_OUT,
   output logic [15:0]               RDATA_OUT,
   output logic                      INVALID_DATA_OUT,
   output logic                      INVALID_PEC_OUT,
   output logic                      READY_OUT,
   // Power stage status and events
   input  wire logic                 CONV_EN_IN,
   input  wire logic [3:0]           STRAP_FOLLOWER_IN,
   input  wire logic                 SHUTDOWN_EVT_IN,
   input  wire logic                 FAULT_RESTART_IN,
   input  wire logic                 RETRY_MODE_IN,
   input  wire logic                 PWM_TICK_IN,
   input  wire logic                 PWM_FAULT_IN,
   input  wire logic                 POWER_GOOD_IN,
   input  wire logic                 RESET_REQ_IN,
   // Configuration outputs
   output pmc_pkg::pmc_cfg_s         CFG_OUT,
   output logic [3:0]                ADC_BITS_OUT,
   output logic                      VOUT_RELOAD_OUT,
   output logic [7:0]                FAULT_COUNT_OUT,
   output logic [3:0]                FOLLOWER_COUNT_OUT,
   // Shared status pin
   output logic                      STATUS_PIN_OUT,
   output logic                      STATUS_PIN_OE_OUT,
   output logic                      STATUS_PULLUP_EN_OUT,
   // Backchannel pins
   output logic                      BC_CLK_ENABLE_OUT,
   output logic                      BC_DATA_ENABLE_OUT,
   output logic                      BC_ACTIVE_LINK_OUT
);
   ////////////////////////////////////////////////////////////////////////////
   // State
   typedef enum logic [1:0] {
      ST_LOAD,
      ST_RUN
   } pmc_phase_e;
   typedef struct packed {
      pmc_phase_e  phase;
      logic [3:0]  follower;
      logic [15:0] assorted;
      logic [15:0] strap_prio;
      logic [3:0]  strap_latched;
      logic        bc_enabled;
      logic        ack;
      logic [15:0] rdata;
      logic        inv_data;
      logic        inv_pec;
      logic        reload;
      logic [7:0]  fault_cnt;
   } pmc_state_s;
   pmc_state_s st_q;
   pmc_state_s st_d;
   logic       conv_en_s;
   logic [3:0] strap_s;
   logic       wr_ok;
   pmc_sync #(.W(5)) u_pin_sync (
      .clk_in  (CLK_SYS_IN),
      .rstn_in (RESETN_IN),
      .ce_in   (CE_IN),
      .d_in    ({CONV_EN_IN, STRAP_FOLLOWER_IN}),
      .q_out   ({conv_en_s, strap_s})
   );
   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      st_d        = st_q;
      st_d.ack    = 1'b0;
      st_d.reload = 1'b0;
      wr_ok       = REQ_IN.pec_ok || !st_q.assorted[pmc_pkg::PEC_REQ_BIT];
      case (st_q.phase)
         ST_LOAD: begin
            // Straps caught once, after reset release
            st_d.strap_latched = strap_s;
            st_d.assorted      = pmc_pkg::NVM_ASSORTED_RST;
            st_d.strap_prio    = pmc_pkg::NVM_STRAP_RST;
            if (pmc_pkg::NVM_STRAP_RST[pmc_pkg::STRAP_TOPOLOGY_BIT]) begin
               st_d.follower = strap_s;
            end else begin
               st_d.follower = pmc_pkg::NVM_STACK_RST[3:0];
            end
            // Backchannel decided only here, at power-up
            st_d.bc_enabled = (st_d.follower != pmc_pkg::STANDALONE_CODE) &&
                              (st_d.follower <= pmc_pkg::FOLLOWER_MAX);
            st_d.phase = ST_RUN;
         end
         ST_RUN: begin
            if (REQ_IN.wr || REQ_IN.rd) begin
               st_d.ack = 1'b1;
               if (!wr_ok) begin
                  st_d.inv_pec = 1'b1;
               end else if (REQ_IN.wr) begin
                  case (REQ_IN.cmd)
                     pmc_pkg::CMD_STACK_TOPOLOGY: begin
                        if (REQ_IN.data[15:4] != 12'h000 ||
                            REQ_IN.data[3:0] > pmc_pkg::FOLLOWER_MAX || conv_en_s) begin
                           st_d.inv_data = 1'b1;
                        end else begin
                           st_d.follower = REQ_IN.data[3:0];
                        end
                     end
                     pmc_pkg::CMD_ASSORTED_SETTINGS: begin
                        st_d.assorted = REQ_IN.data & pmc_pkg::ASSORTED_WR_MASK;
                     end
                     pmc_pkg::CMD_STRAP_PRIORITY: begin
                        st_d.strap_prio = REQ_IN.data;
                     end
                     default: begin
                        st_d.inv_data = 1'b1;
                     end
                  endcase
               end else begin
                  case (REQ_IN.cmd)
                     pmc_pkg::CMD_STACK_TOPOLOGY: begin
                        st_d.rdata = {12'h000, st_q.follower};
                     end
                     pmc_pkg::CMD_ASSORTED_SETTINGS: begin
                        st_d.rdata = st_q.assorted;
                     end
                     pmc_pkg::CMD_STRAP_PRIORITY: begin
                        st_d.rdata = st_q.strap_prio;
                     end
                     default: begin
                        st_d.rdata    = 16'h0000;
                        st_d.inv_data = 1'b1;
                     end
                  endcase
               end
            end
            // Output voltage target reload requests
            if (SHUTDOWN_EVT_IN && st_q.assorted[pmc_pkg::RELOAD_SHDN_BIT]) begin
               st_d.reload = 1'b1;
            end
            if (FAULT_RESTART_IN && RETRY_MODE_IN &&
                st_q.assorted[pmc_pkg::RELOAD_FLT_BIT]) begin
               st_d.reload = 1'b1;
            end
            // Fault counter
            if (PWM_TICK_IN) begin
               if (PWM_FAULT_IN) begin
                  if (st_q.fault_cnt != 8'hFF) begin
                     st_d.fault_cnt = st_q.fault_cnt + 8'h01;
                  end
               end else if (st_q.assorted[pmc_pkg::FLT_CLR_BIT]) begin
                  st_d.fault_cnt = 8'h00;
               end else if (st_q.fault_cnt != 8'h00) begin
                  st_d.fault_cnt = st_q.fault_cnt - 8'h01;
               end
            end
         end
         default: begin
            st_d.phase = ST_LOAD;
         end
      endcase
   end
   always_ff @(posedge CLK_SYS_IN) begin
      if (!RESETN_IN) begin
         st_q       <= '0;
         st_q.phase <= ST_LOAD;
      end else if (CE_IN) begin
         st_q <= st_d;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Link domain view of the backchannel enable
   logic bc_link_s;
   pmc_sync #(.W(1)) u_link_sync (
      .clk_in  (CLK_LINK_IN),
      .rstn_in (RESETN_IN),
      .ce_in   (1'b1),
      .d_in    (st_q.bc_enabled),
      .q_out   (bc_link_s)
   );
   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign READY_OUT          = (st_q.phase == ST_RUN);
   assign ACK_OUT            = st_q.ack;
   assign RDATA_OUT          = st_q.rdata;
   assign INVALID_DATA_OUT   = st_q.inv_data;
   assign INVALID_PEC_OUT    = st_q.inv_pec;
   assign VOUT_RELOAD_OUT    = st_q.reload;
   assign FAULT_COUNT_OUT    = st_q.fault_cnt;
   assign FOLLOWER_COUNT_OUT = st_q.follower;
   assign BC_CLK_ENABLE_OUT  = st_q.bc_enabled;
   assign BC_DATA_ENABLE_OUT = st_q.bc_enabled;
   assign BC_ACTIVE_LINK_OUT = bc_link_s;
   always_comb begin
      CFG_OUT                    = '0;
      CFG_OUT.pec_required       = st_q.assorted[pmc_pkg::PEC_REQ_BIT];
      CFG_OUT.reload_shutdown    = st_q.assorted[pmc_pkg::RELOAD_SHDN_BIT];
      CFG_OUT.reload_fault       = st_q.assorted[pmc_pkg::RELOAD_FLT_BIT];
      CFG_OUT.reset_mode         = st_q.assorted[pmc_pkg::RESET_MODE_BIT];
      CFG_OUT.pullup_en          = st_q.assorted[pmc_pkg::RESET_MODE_BIT] &&
                                   !st_q.assorted[pmc_pkg::PULLUP_DIS_BIT];
      CFG_OUT.fault_clear_mode   = st_q.assorted[pmc_pkg::FLT_CLR_BIT];
      CFG_OUT.adc_resolution_sel = st_q.assorted[pmc_pkg::ADC_RESOLUTION_SEL_LSB +: 2];
      case (st_q.assorted[pmc_pkg::ADC_RESOLUTION_SEL_LSB +: 2])
         2'h0:    ADC_BITS_OUT = 4'hC;
         2'h1:    ADC_BITS_OUT = 4'hA;
         2'h2:    ADC_BITS_OUT = 4'h8;
         default: ADC_BITS_OUT = 4'h6;
      endcase
   end
   // Pin drives low only; open-drain style
   assign STATUS_PIN_OUT       = 1'b0;
   assign STATUS_PIN_OE_OUT    = st_q.assorted[pmc_pkg::RESET_MODE_BIT] ?
                                 RESET_REQ_IN : !POWER_GOOD_IN;
   assign STATUS_PULLUP_EN_OUT = st_q.assorted[pmc_pkg::RESET_MODE_BIT] &&
                                 !st_q.assorted[pmc_pkg::PULLUP_DIS_BIT];
endmodule : pmc_config_regs

// file: tb/pmc_monitor.sv
// Port checker for the configuration register bank
module pmc_monitor (
   // Clock, reset and transactions
   input wire logic              CLK_SYS_IN,
   input wire logic              RESETN_IN,
   input wire logic              CE_IN,
   input wire pmc_pkg::pmc_req_s REQ_IN,
   input wire logic              ACK_OUT,
   input wire logic [15:0]       RDATA_OUT,
   input wire logic              INVALID_DATA_OUT,
   input wire logic              INVALID_PEC_OUT,
   input wire logic              READY_OUT,
   // Power stage status and events
   input wire logic              CONV_EN_IN,
   input wire logic              SHUTDOWN_EVT_IN,
   input wire logic              FAULT_RESTART_IN,
   input wire logic              RETRY_MODE_IN,
   input wire logic              PWM_TICK_IN,
   input wire logic              PWM_FAULT_IN,
   input wire logic              POWER_GOOD_IN,
   input wire logic              RESET_REQ_IN,
   // Configuration and pins
   input wire pmc_pkg::pmc_cfg_s CFG_OUT,
   input wire logic [3:0]        ADC_BITS_OUT,
   input wire logic              VOUT_RELOAD_OUT,
   input wire logic [7:0]        FAULT_COUNT_OUT,
   input wire logic [3:0]        FOLLOWER_COUNT_OUT,
   input wire logic              STATUS_PIN_OE_OUT,
   input wire logic              STATUS_PULLUP_EN_OUT,
   input wire logic              BC_CLK_ENABLE_OUT,
   input wire logic              BC_DATA_ENABLE_OUT
);
   timeunit 1ns;
   timeprecision 1ns;
   ////////////////////////////////////////////////////////////////////////////////
   logic taken, pec_bad, topo_wr, rl_cond;
   assign taken = CE_IN && READY_OUT && (REQ_IN.wr || REQ_IN.rd);
   assign pec_bad = CFG_OUT.pec_required && !REQ_IN.pec_ok;
   assign topo_wr = taken && REQ_IN.wr && !pec_bad && REQ_IN.cmd == pmc_pkg::CMD_STACK_TOPOLOGY;
   assign rl_cond = CE_IN && (SHUTDOWN_EVT_IN && CFG_OUT.reload_shutdown
                              || FAULT_RESTART_IN && RETRY_MODE_IN && CFG_OUT.reload_fault);
   default clocking @(posedge CLK_SYS_IN); endclocking
   default disable iff (!RESETN_IN);
   sequence s_conv_on; CONV_EN_IN [*4]; endsequence
   sequence s_conv_off; !CONV_EN_IN [*4]; endsequence
   ////////////////////////////////////////////////////////////////////////////////
   property p_ack; $past(CE_IN) |-> ACK_OUT == $past(taken); endproperty
   a_ack: assert property (p_ack) else $error("ack not one cycle after request");
   property p_topo_ok;
      s_conv_off ##0 (topo_wr && REQ_IN.data <= 16'h0003)
         |=> FOLLOWER_COUNT_OUT == $past(REQ_IN.data[3:0]);
   endproperty
   a_topo_ok: assert property (p_topo_ok) else $error("valid topology lost");
   property p_topo_bad;
      (s_conv_on ##0 topo_wr) or (topo_wr && REQ_IN.data > 16'h0003)
         |=> INVALID_DATA_OUT && $stable(FOLLOWER_COUNT_OUT);
   endproperty
   a_topo_bad: assert property (p_topo_bad) else $error("bad topology taken");
   property p_rd_topo;
      taken && !REQ_IN.wr && !pec_bad && REQ_IN.cmd == pmc_pkg::CMD_STACK_TOPOLOGY
         |=> RDATA_OUT == {12'h000, FOLLOWER_COUNT_OUT};
   endproperty
   a_rd_topo: assert property (p_rd_topo) else $error("topology read wrong");
   property p_pec;
      taken && REQ_IN.wr && pec_bad |=> INVALID_PEC_OUT && $stable(CFG_OUT);
   endproperty
   a_pec: assert property (p_pec) else $error("missing check byte accepted");
   property p_adc; $stable(CFG_OUT) |-> ADC_BITS_OUT == 4'hC - {CFG_OUT.adc_resolution_sel, 1'b0};
   endproperty
   a_adc: assert property (p_adc) else $error("adc resolution wrong");
   property p_pin;
      $stable(CFG_OUT) && $stable(POWER_GOOD_IN) && $stable(RESET_REQ_IN)
         |-> STATUS_PIN_OE_OUT == (CFG_OUT.reset_mode ? RESET_REQ_IN : !POWER_GOOD_IN)
         && STATUS_PULLUP_EN_OUT == (CFG_OUT.reset_mode && CFG_OUT.pullup_en);
   endproperty
   a_pin: assert property (p_pin) else $error("status pin wrong");
   property p_reload; $past(CE_IN) |-> VOUT_RELOAD_OUT == $past(rl_cond); endproperty
   a_reload: assert property (p_reload) else $error("reload pulse wrong");
   property p_fault;
      CE_IN && PWM_TICK_IN && !PWM_FAULT_IN |=> FAULT_COUNT_OUT ==
         (($past(CFG_OUT.fault_clear_mode) || $past(FAULT_COUNT_OUT) == 8'h00) ? 8'h00
          : $past(FAULT_COUNT_OUT) - 8'h01);
   endproperty
   a_fault: assert property (p_fault) else $error("fault counter wrong");
   property p_bc;
      $past(READY_OUT) |-> $stable(BC_CLK_ENABLE_OUT) && BC_DATA_ENABLE_OUT == BC_CLK_ENABLE_OUT;
   endproperty
   a_bc: assert property (p_bc) else $error("backchannel changed live");
endmodule : pmc_monitor
bind pmc_config_regs pmc_monitor i_mon (.*);

// file: tb/pmc_host_model.sv
// Host model issuing word reads and writes
module pmc_host_model (
   // Clock and answer
   input  wire logic        clk_in,
   input  wire logic        ack_in,
   input  wire logic [15:0] rdata_in,
   // Request
   output pmc_pkg::pmc_req_s req_out
);
   timeunit 1ns;
   timeprecision 1ns;
   initial req_out = '0;
   task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                       input logic p, output logic [15:0] r);
      @(posedge clk_in);
      req_out <= '{w, !w, p, c, d};
      @(posedge clk_in);
      req_out <= '{1'b0, 1'b0, !p, ~c, ~d};
      @(posedge clk_in);
      r = ack_in ? rdata_in : 16'hXXXX;
   endtask : xfer
endmodule : pmc_host_model

// file: tb/pmc_config_regs_tb.sv
// Testbench for the configuration register bank
module pmc_config_regs_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic              clk = 1'b0, lclk = 1'b0, rst_n = 1'b0, conv = 1'b0, pg = 1'b1;
   logic              ce = 1'b1, rrq = 1'b0, oe;
   logic [4:0]        evt = '0;
   logic              ack, inv_d, inv_p, ready, rl, pull, bc_c, bc_d, bc_l;
   logic [15:0]       rdata, rd;
   logic [7:0]        fcnt;
   logic [3:0]        adc, fol;
   int                miscompares = 0, samples_checked = 0, cycles = 0;
   pmc_pkg::pmc_req_s req;
   pmc_host_model i_host (.clk_in(clk), .ack_in(ack), .rdata_in(rdata), .req_out(req));
   pmc_config_regs i_dut (.CLK_SYS_IN(clk), .RESETN_IN(rst_n), .CE_IN(ce), .CLK_LINK_IN(lclk),
      .REQ_IN(req), .ACK_OUT(ack), .RDATA_OUT(rdata), .INVALID_DATA_OUT(inv_d),
      .INVALID_PEC_OUT(inv_p), .READY_OUT(ready), .CONV_EN_IN(conv), .STRAP_FOLLOWER_IN(4'h2),
      .SHUTDOWN_EVT_IN(evt[4]), .FAULT_RESTART_IN(evt[3]), .RETRY_MODE_IN(evt[2]),
      .PWM_TICK_IN(evt[1]), .PWM_FAULT_IN(evt[0]), .POWER_GOOD_IN(pg), .RESET_REQ_IN(rrq),
      .CFG_OUT(), .ADC_BITS_OUT(adc), .VOUT_RELOAD_OUT(rl), .FAULT_COUNT_OUT(fcnt),
      .FOLLOWER_COUNT_OUT(fol), .STATUS_PIN_OUT(), .STATUS_PIN_OE_OUT(oe),
      .STATUS_PULLUP_EN_OUT(pull), .BC_CLK_ENABLE_OUT(bc_c), .BC_DATA_ENABLE_OUT(bc_d),
      .BC_ACTIVE_LINK_OUT(bc_l));
   initial forever #25 clk = ~clk;
   initial begin
      #7;
      forever #16 lclk = ~lclk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask : check
   task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic p = 1'b1);
      i_host.xfer(1'b1, c, d, p, rd);
   endtask : wr
   task automatic rdchk(input string n, input logic [7:0] c, input logic [15:0] e);
      i_host.xfer(1'b0, c, 16'h0000, 1'b1, rd);
      check(n, e, rd);
   endtask : rdchk
   task automatic pulse(input logic [4:0] v, input int k = 1);
      repeat (k) begin
         @(posedge clk);
         evt <= v;
         @(posedge clk);
         evt <= '0;
         @(posedge clk);
      end
   endtask : pulse
   task automatic conclude;
      $display("checked %0d miscompares %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : conclude
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         miscompares++;
         conclude();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      for (int k = 0; k < 8 && ready !== 1'b1; k++) @(posedge clk);
      check("load", {12'h000, pmc_pkg::NVM_STACK_RST[3:0]}, {12'h000, fol});
      check("bc", 16'h0000, {13'h0000, bc_c, bc_d, bc_l});
      rdchk("topo", pmc_pkg::CMD_STACK_TOPOLOGY, 16'h0000);
      wr(pmc_pkg::CMD_STACK_TOPOLOGY, 16'h0003);
      rdchk("topo", pmc_pkg::CMD_STACK_TOPOLOGY, 16'h0003);
      check("bc", 16'h0000, {13'h0000, bc_c, bc_d, bc_l});
      wr(pmc_pkg::CMD_STACK_TOPOLOGY, 16'h0013);
      wr(pmc_pkg::CMD_STACK_TOPOLOGY, 16'h0004);
      rdchk("topo", pmc_pkg::CMD_STACK_TOPOLOGY, 16'h0003);
      check("inv", 16'h0001, {15'h0000, inv_d});
      conv <= 1'b1;
      repeat (4) @(posedge clk);
      wr(pmc_pkg::CMD_STACK_TOPOLOGY, 16'h0001);
      rdchk("topo", pmc_pkg::CMD_STACK_TOPOLOGY, 16'h0003);
      conv <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         rrq <= i[1];
         wr(pmc_pkg::CMD_ASSORTED_SETTINGS, (i[0] ? 16'h7004 : 16'h1008) | 16'(i));
         rdchk("set", pmc_pkg::CMD_ASSORTED_SETTINGS, (i[0] ? 16'h7004 : 16'h1008) | 16'(i));
         check("adc", 16'(12 - 2 * i), {12'h000, adc});
         check("pull", 16'(i[0]), {15'h0000, pull});
         check("oe", 16'(i[1]), {15'h0000, oe});
      end
      pulse(5'b10000);
      check("rl", 16'h0001, {15'h0000, rl});
      pulse(5'b01000);
      check("rl", 16'h0000, {15'h0000, rl});
      pulse(5'b01100);
      check("rl", 16'h0001, {15'h0000, rl});
      pulse(5'b00011, 3);
      pulse(5'b00010);
      check("fcnt", 16'h0000, {8'h00, fcnt});
      wr(pmc_pkg::CMD_ASSORTED_SETTINGS, 16'h1008);
      pulse(5'b00011, 3);
      pulse(5'b00010);
      check("fcnt", 16'h0002, {8'h00, fcnt});
      ce <= 1'b0;
      pulse(5'b00010);
      check("ce", 16'h0002, {8'h00, fcnt});
      ce <= 1'b1;
      pulse(5'b10000);
      check("rl", 16'h0000, {15'h0000, rl});
      wr(pmc_pkg::CMD_ASSORTED_SETTINGS, 16'h8000);
      pg <= 1'b0;
      wr(pmc_pkg::CMD_ASSORTED_SETTINGS, 16'h0000, 1'b0);
      rdchk("pec", pmc_pkg::CMD_ASSORTED_SETTINGS, 16'h8000);
      check("inv_pec", 16'h0001, {15'h0000, inv_p});
      check("oe", 16'h0001, {15'h0000, oe});
      wr(pmc_pkg::CMD_STRAP_PRIORITY, 16'h1000);
      rdchk("strap", pmc_pkg::CMD_STRAP_PRIORITY, 16'h1000);
      rdchk("topo", pmc_pkg::CMD_STACK_TOPOLOGY, 16'h0003);
      rdchk("unk", 8'hEF, 16'h0000);
      wr(pmc_pkg::CMD_STRAP_PRIORITY, 16'h0000);
      rst_n <= 1'b0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      check("reload", pmc_pkg::NVM_STACK_RST, {12'h000, fol});
      check("bc", 16'h0000, {13'h0000, bc_c, bc_d, bc_l});
      check("inv", 16'h0000, {14'h0000, inv_d, inv_p});
      rdchk("strap", pmc_pkg::CMD_STRAP_PRIORITY, pmc_pkg::NVM_STRAP_RST);
      conclude();
   end
endmodule : pmc_config_regs_tb
